/* vfd_pkg.sv */
/*
  constants, field layout and carrier types of the serial display controller.
  assumes one 50 MHz system clock and a host that drives the serial link pins.
*/
// How it works
// R01 - first word with top bits 00 loads its five low bits as RAM address
// R02 - next word is written at the held address, address advances together
// R03 - any number of display bytes follow one address word within a transfer
// R04 - host gives only starting addresses 00H through 1DH
// R05 - five-bit counter runs through 1EH and 1FH, then wraps to 00H
// R06 - bytes written at 1EH or 1FH have no effect on the display
// R07 - display RAM holds thirty eight-bit locations, two per character slot
// R08 - slot k uses 2k for segments 0-7, 2k+1 for 8-15; slots 1-14 drive grids
// R09 - first word with top bit 1 loads its seven low bits into configuration
// R10 - configuration bits 6-4 duty, bit 3 display on, bits 2-0 shift count
// R11 - host changes duty or shift count only while display is off
// R12 - reset returns configuration to duty 2/16 with display off
// R13 - duty codes 0-6 give 2/16 to 14/16 in steps of two, code 7 gives 15/16
// R14 - display bit 1 turns display on; 0 blanks every segment and grid output
// R15 - shift loop length is the shift field value plus seven digits
// R16 - serial bit sampled on clock rise; word taken on chip select rise
// R17 - after a command first word the rest of the transfer is ignored
// R18 - shifting applies up to the shift count; later positions show own images; code keeps start_slot at 1, so every grid g shows slot g+1
package vfd_pkg;
  localparam int ram_depth = 30;
  localparam int slot_count = 15;
  localparam int grid_count = 14;
  localparam int seg_count = 16;
  localparam int word_bits = 8;
  localparam int addr_bits = 5;
  localparam int sub_slots = 16;
  localparam logic [4:0] addr_last_used = 5'h1D;
  localparam logic [4:0] addr_gap_lo = 5'h1E;
  localparam logic [4:0] addr_gap_hi = 5'h1F;
  localparam int cmd_bit = 7;
  localparam int addr_sel_hi = 6;
  localparam logic [3:0] shift_base = 4'h7;
  localparam logic [3:0] start_slot = 4'h1;
  localparam logic [2:0] duty_code_full = 3'h7;
  localparam logic [4:0] duty_full = 5'h0F;
  localparam logic [2:0] cfg_duty_reset = 3'h0;
  localparam logic cfg_on_reset = 1'b0;
  localparam logic [2:0] cfg_shift_reset = 3'h7;
  localparam int scan_div_default = 50;

  typedef struct packed {
    logic [2:0] duty;
    logic on;
    logic [2:0] shift;
  } display_config_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } link_word_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_data = 2'b01,
    st_skip = 2'b10
  } decode_state_t;
endpackage

/* vfd_serial_command_ram.sv */
/*
  serial word decoder, address counter, display RAM, configuration register and
  a simple grid scanner. assumes link pins are asynchronous to clk and slow
  enough (bit clock well under clk/4) to be oversampled.
*/
`timescale 1ns/100ps
`default_nettype none
module vfd_serial_command_ram
  import vfd_pkg::*;
#(
  parameter int scan_div = scan_div_default
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin,
  input wire logic chip_select_pin_n,
  output logic link_ready,
  output logic [seg_count-1:0] segment_outputs,
  output logic [grid_count-1:0] digit_grid_outputs,
  output display_config_t display_config_register
);
  // the sub-slot divider needs at least one bit of count
  if (scan_div < 2)
  begin
    $error("scan_div must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sck_r;
  logic [1:0] sdi_r;
  logic [2:0] csn_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // idle level of the link clock is high, so no false rise after reset
      sck_r <= 3'h7;
      sdi_r <= 2'h0;
      csn_r <= 3'h7;
    end
    else
    begin
      sck_r <= {sck_r[1:0], serial_clk_pin};
      sdi_r <= {sdi_r[0], serial_data_pin};
      csn_r <= {csn_r[1:0], chip_select_pin_n};
    end
  end

  logic sck_rise;
  logic cs_fall;
  logic cs_rise;
  logic cs_active;
  assign sck_rise = sck_r[1] && !sck_r[2];
  assign cs_fall = !csn_r[1] && csn_r[2];
  assign cs_rise = csn_r[1] && !csn_r[2];
  assign cs_active = !csn_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // word assembly: a full word is held until the next bit or the chip select rise
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic hold_valid_r;
  link_word_t hold_r;
  logic first_pending_r;
  logic push;
  link_word_t push_word;
  logic fifo_full;

  assign push = hold_valid_r && (cs_rise || (cs_active && sck_rise));  // [R16]
  assign push_word = hold_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      hold_valid_r <= 1'b0;
      hold_r <= '0;
      first_pending_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_cnt_r <= 3'h0;
      hold_valid_r <= 1'b0;
      first_pending_r <= 1'b1;
    end
    else if (cs_active && sck_rise)
    begin
      shift_r <= {shift_r[6:0], sdi_r[1]};  // [R16]
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7)
      begin
        hold_valid_r <= 1'b1;
        hold_r <= '{first: first_pending_r, data: {shift_r[6:0], sdi_r[1]}};
        first_pending_r <= 1'b0;
      end
      else if (push)
        hold_valid_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      hold_valid_r <= 1'b0;
      bit_cnt_r <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer between link and decoder
  link_word_t fifo_mem [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] fifo_cnt_r;
  logic fifo_valid;
  logic pop;
  logic drain_ready;
  link_word_t head;

  assign fifo_full = fifo_cnt_r == 2'h2;
  assign fifo_valid = fifo_cnt_r != 2'h0;
  assign head = fifo_mem[rd_ptr_r];
  assign pop = fifo_valid && drain_ready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fifo_cnt_r <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end
    else
    begin
      if (push && !fifo_full)
      begin
        fifo_mem[wr_ptr_r] <= push_word;
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= !rd_ptr_r;
      if ((push && !fifo_full) && !pop)
        fifo_cnt_r <= fifo_cnt_r + 2'h1;
      else if (!(push && !fifo_full) && pop)
        fifo_cnt_r <= fifo_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      link_ready <= 1'b1;
    else
      link_ready <= (fifo_cnt_r == 2'h0) || ((fifo_cnt_r == 2'h1) && !push) || pop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoder, address counter and display RAM
  decode_state_t state_r;
  logic [addr_bits-1:0] addr_r;
  logic [7:0] ram [ram_depth];  // [R07]
  logic take_data;
  logic ram_we;
  logic scan_read;

  assign drain_ready = !scan_read;
  assign take_data = pop && !head.first && state_r == st_data;
  assign ram_we = take_data && addr_r <= addr_last_used;  // [R06]

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= st_idle;
      addr_r <= 5'h00;
      display_config_register <= '{duty: cfg_duty_reset, on: cfg_on_reset,
                                   shift: cfg_shift_reset};  // [R12]
    end
    else if (pop)
    begin
      if (head.first)
      begin
        if (head.data[cmd_bit])
        begin
          display_config_register <= display_config_t'(head.data[6:0]);  // [R09] [R10]
          state_r <= st_skip;  // [R17]
        end
        else if (!head.data[addr_sel_hi])
        begin
          addr_r <= head.data[4:0];  // [R01]
          state_r <= st_data;
        end
        else
          state_r <= st_skip;  // [R17]
      end
      else if (state_r == st_data)
        addr_r <= addr_r + 5'h01;  // [R02] [R03] [R05]
    end
  end

  always_ff @(posedge clk)
  begin
    if (ram_we)  // [R06]
      ram[addr_r] <= head.data;  // [R02]
  end

  ////////////////////////////////////////////////////////////////////////////
  // scanner: sub-slot divider, grid counter, duty window, slot mapping
  logic [$clog2(scan_div)-1:0] div_r;
  logic sub_tick;
  logic [3:0] sub_r;
  logic [3:0] grid_r;
  logic [3:0] grid_nxt;
  logic [15:0] seg_cur_r;
  logic [4:0] duty_len;
  logic [3:0] loop_len;
  logic [3:0] slot_sel;

  function automatic logic [4:0] duty_sixteenths(input logic [2:0] code);
    if (code == duty_code_full)
      duty_sixteenths = duty_full;  // [R13]
    else
      duty_sixteenths = {1'b0, code, 1'b0} + 5'h02;  // [R13]
  endfunction

  function automatic logic [3:0] slot_for_grid(input logic [3:0] grid,
                                               input logic [3:0] len);
    logic [4:0] sum;
    sum = {1'b0, start_slot} + {1'b0, grid};
    if (grid >= len)
      slot_for_grid = grid + 4'h1;  // [R18]
    else if (sum > {1'b0, len})
      slot_for_grid = sum[3:0] - len - 4'h1;  // [R18]
    else
      slot_for_grid = sum[3:0];
  endfunction

  assign sub_tick = div_r == ($clog2(scan_div))'(scan_div - 1);
  assign duty_len = duty_sixteenths(display_config_register.duty);
  assign loop_len = {1'b0, display_config_register.shift} + shift_base;  // [R15]
  // segment data is fetched for the grid that is about to be lit
  assign grid_nxt = (grid_r == 4'(grid_count - 1)) ? 4'h0 : grid_r + 4'h1;
  assign slot_sel = slot_for_grid(grid_nxt, loop_len);
  assign scan_read = sub_tick && sub_r == 4'hF;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r <= '0;
      sub_r <= 4'h0;
      grid_r <= 4'h0;
      seg_cur_r <= 16'h0000;
    end
    else
    begin
      div_r <= sub_tick ? '0 : div_r + 1'b1;
      if (sub_tick)
        sub_r <= sub_r + 4'h1;
      if (scan_read)
      begin
        grid_r <= grid_nxt;
        seg_cur_r <= {ram[{slot_sel, 1'b1}], ram[{slot_sel, 1'b0}]};  // [R08]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      segment_outputs <= '0;
      digit_grid_outputs <= '0;
    end
    else if (!display_config_register.on)
    begin
      segment_outputs <= '0;  // [R14]
      digit_grid_outputs <= '0;  // [R14]
    end
    else
    begin
      segment_outputs <= seg_cur_r;
      digit_grid_outputs <= ({1'b0, sub_r} < duty_len) ? 14'(1) << grid_r : '0;  // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence first_cmd;
    pop && head.first && head.data[cmd_bit];
  endsequence
  sequence first_addr;
    pop && head.first && head.data[7:6] == 2'b00;
  endsequence

  a_addr_load: assert property (@(posedge clk) disable iff (!rstn)  // [R01]
    first_addr |=> addr_r == $past(head.data[4:0]) && state_r == st_data)
    else $error("address word not loaded");
  a_data_store: assert property (@(posedge clk) disable iff (!rstn)  // [R02]
    (take_data && addr_r < 5'(ram_depth)) |=>
      ram[$past(addr_r)] == $past(head.data) && addr_r == $past(addr_r) + 5'h01)
    else $error("display byte not stored with increment");
  a_gap_pass: assert property (@(posedge clk) disable iff (!rstn)  // [R05]
    (take_data && addr_r == addr_gap_hi) |=> addr_r == 5'h00)
    else $error("address counter did not wrap");
  a_gap_ignore: assert property (@(posedge clk) disable iff (!rstn)  // [R06]
    (take_data && addr_r >= addr_gap_lo) |-> !ram_we)
    else $error("gap write disturbed display");
  a_cfg_load: assert property (@(posedge clk) disable iff (!rstn)  // [R09]
    first_cmd |=> display_config_register == $past(head.data[6:0]) ##1 state_r == st_skip)
    else $error("configuration not loaded");
  a_cfg_ignore: assert property (@(posedge clk) disable iff (!rstn)  // [R17]
    (state_r == st_skip && !(pop && head.first)) |=> $stable(display_config_register)
      && $stable(addr_r))
    else $error("word after command not ignored");
  a_blank_off: assert property (@(posedge clk) disable iff (!rstn)  // [R14]
    !display_config_register.on[*2] |-> segment_outputs == '0 && digit_grid_outputs == '0)
    else $error("outputs not blank while display off");
  a_duty_gate: assert property (@(posedge clk) disable iff (!rstn)  // [R13]
    digit_grid_outputs != '0 |-> $past({1'b0, sub_r} < duty_len))
    else $error("grid active outside duty window");
  a_word_take: assert property (@(posedge clk) disable iff (!rstn)  // [R16]
    (hold_valid_r && cs_rise && !fifo_full) |=> fifo_cnt_r != 2'h0)
    else $error("word not taken at chip select rise");
endmodule
`default_nettype wire

/* host_link_model.sv */
/*
  host side of the serial link: frames 8-bit words msb first, 8 clk per bit.
  assumes the bench calls send_frame from one process at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module host_link_model
(
  input wire logic clk,
  output logic sck,
  output logic sdi,
  output logic csn_n
);
  initial
  begin
    sck = 1'b1;
    sdi = 1'b1;
    csn_n = 1'b1;
  end

  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // bits go out from bit nbits-1 downwards; nbits may stop short of a whole word
  task automatic send_frame(input logic [71:0] w, input int nbits);
    csn_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      sck = 1'b0;
      sdi = w[nbits - 1 - i]; // msb first
      half();
      sck = 1'b1; // bit sampled on this rise
      half();
    end
    csn_n = 1'b1; // last word taken on this rise
    sdi = ~sdi;
    repeat (12) half();
  endtask
endmodule
`default_nettype wire

/* vfd_serial_command_ram_tb.sv */
/*
  self-checking bench for the serial display controller.
  assumes the host model above and a short scan divider of 2.
*/
`timescale 1ns/100ps
`default_nettype none
module vfd_serial_command_ram_tb;
  import vfd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire logic sck;
  wire logic sdi;
  wire logic csn_n;
  wire logic link_ready;
  wire logic [15:0] seg;
  wire logic [13:0] grid;
  display_config_t cfg;
  int err_count = 0;
  int samples_checked = 0;
  int n;

  always #10 clk = ~clk;

  host_link_model i_host
  (
    .clk(clk),
    .sck(sck),
    .sdi(sdi),
    .csn_n(csn_n)
  );

  vfd_serial_command_ram #(.scan_div(2)) i_dut
  (
    .clk(clk),
    .rstn(rstn),
    .serial_clk_pin(sck),
    .serial_data_pin(sdi),
    .chip_select_pin_n(csn_n),
    .link_ready(link_ready),
    .segment_outputs(seg),
    .digit_grid_outputs(grid),
    .display_config_register(cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // extra word follows the command word in the same frame
  task automatic set_cfg(input logic [2:0] d, input logic on, input logic [2:0] s,
                         input logic [7:0] extra);
    i_host.send_frame(72'({1'b1, d, on, s, extra}), 16);
  endtask

  // returns in the first cycle that grid g is lit
  task automatic wait_grid(input int g);
    int t;
    t = 0;
    while (grid === 14'(1 << g) && t < 3000)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    while (grid !== 14'(1 << g) && t < 3000)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t >= 3000)
    begin
      err_count++;
      $display("MISMATCH at %0t: grid %0d never lit", $time, g);
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    check(16'(cfg), 16'h0007);
    check(seg, 16'h0000);
    check(16'(grid), 16'h0000);
    check(16'(link_ready), 16'h0001);
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (int d = 0; d < 8; d++)
    begin
      set_cfg(3'(d), 1'b0, 3'(7 - d), {1'b1, ~3'(d), 1'b1, 3'(d)});
      check(16'(cfg), 16'({3'(d), 1'b0, 3'(7 - d)}));
    end
    // bit 5 set in the address word must not matter; 1C is a legal start
    i_host.send_frame(72'h3C_A1_A2_E1_E2_B0_B1_B2_B3, 72);
    set_cfg(3'h0, 1'b0, 3'h7, 8'h00);
    set_cfg(3'h0, 1'b1, 3'h7, 8'h00);
    wait_grid(13);
    @(posedge clk);
    #1;
    check(seg, 16'hA2A1);
    wait_grid(0);
    @(posedge clk);
    #1;
    check(seg, 16'hB3B2);
    for (int d = 0; d < 8; d++)
    begin
      set_cfg(cfg.duty, 1'b0, 3'h7, 8'h00);
      set_cfg(3'(d), 1'b0, 3'h7, 8'h00);
      set_cfg(3'(d), 1'b1, 3'h7, 8'h00);
      wait_grid(0);
      n = 0;
      repeat (32)
      begin
        if (grid[0] === 1'b1)
          n++;
        @(posedge clk);
        #1;
      end
      check(16'(n), (d == 7) ? 16'h001E : 16'(4 * (d + 1)));
    end
    // reset in mid-run while the display is lit
    rstn = 1'b0;
    @(posedge clk);
    #1;
    check(16'(cfg), 16'h0007);
    check(seg, 16'h0000);
    check(16'(grid), 16'h0000);
    check(16'(link_ready), 16'h0001);
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    set_cfg(3'h0, 1'b0, 3'h7, 8'h00);
    n = 0;
    repeat (600)
    begin
      if (seg !== 16'h0000 || grid !== 14'h0000)
        n++;
      @(posedge clk);
      #1;
    end
    check(16'(n), 16'h0000);
    check(16'(link_ready), 16'h0001);
    summarize();
  end
endmodule
`default_nettype wire
